// File: bench/ebs_mem_model.sv
// Purpose: slow external memory seen through the ready line
// Assumes: access strobe low marks a bus cycle
// Notes:   in slow mode ready idles low and rises after HOLD cycles
module ebs_mem_model #(
	parameter int HOLD = 4
) (
	// Clock
	input  wire logic core_clk,
	// Bench control and bus
	input  wire logic slow,
	input  wire logic ext_access_strobe_n,
	// Answer
	output logic      ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial ready = 1'h1;
	always @(posedge core_clk) begin
		if (!slow) begin
			ready <= 1'h1;
		end else if (!ext_access_strobe_n) begin
			cnt = cnt + 1;
			ready <= (cnt >= HOLD);
		end else begin
			// Low ahead of the cycle, so the two-flop sync sees it in time
			cnt = 0;
			ready <= 1'h0;
		end
	end
endmodule : ebs_mem_model

// File: bench/tb_ext_bus_strobe_control.sv
// Purpose: self-checking bench of the bus strobe control
// Assumes: one request at a time, released in the done cycle except in the back-to-back run
// Notes:   a stretched cycle is checked as longer than its wait states
module tb_ext_bus_strobe_control;
	timeunit 1ns;
	timeprecision 1ns;
	import ebs_pkg::*;
	logic core_clk, done, ready, slow = 0, rst_n = 0, req = 0, req_write = 0;
	logic port_c_bit0_sel_qual = 0, port_c_bit0_gpio_dir_out = 0, port_c_bit0_gpio_out = 0;
	logic debug_pin_one_float_n = 1, test_reset = 0, debug_pin_zero = 0, port_c_bit0_gpio_i = 0;
	logic [1:0] req_space = 0;
	logic [EBS_WS_W-1:0] wait_state_config = 0;
	logic port_c_bit0_gpio_val, ext_access_strobe_n, read_strobe_n, write_strobe_n, rd_wr_dir;
	logic prog_space_strobe_n, data_space_strobe_n, io_space_select_n, strobe_oe_n;
	logic port_c_bit0_gpio_o, port_c_bit0_gpio_oe_n, data_bus_oe_n;
	logic [31:0] rng = 32'h0B43B587;
	logic [23:0] exp_q[$];
	logic [7:0]  ocnt = 0;
	logic [2:0]  osp = 0;
	logic        ord = 0, owr = 0, odl = 0;
	int          bad_count = 0, comparisons = 0;

	ebs_strobe_ctrl uut (.core_clk, .rst_n, .req, .req_write, .req_space, .wait_state_config,
		.port_c_bit0_sel_qual, .port_c_bit0_gpio_dir_out, .port_c_bit0_gpio_out, .done, .ready,
		.debug_pin_one_float_n, .test_reset, .debug_pin_zero, .port_c_bit0_gpio_i,
		.port_c_bit0_gpio_val, .ext_access_strobe_n, .read_strobe_n, .write_strobe_n, .rd_wr_dir,
		.prog_space_strobe_n, .data_space_strobe_n, .io_space_select_n, .strobe_oe_n,
		.port_c_bit0_gpio_o, .port_c_bit0_gpio_oe_n, .data_bus_oe_n);
	ebs_mem_model mem (.core_clk, .slow, .ext_access_strobe_n, .ready);

	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Driver: request, note, wait for done
	// ----------------------------------------
	task automatic access(input logic wr, input logic [1:0] sp, input logic [2:0] w);
		req <= 1'h1;
		req_write <= wr;
		req_space <= sp;
		wait_state_config <= w;
		exp_q.push_back({8'(1 + w), 2'h0, (sp == 2'h3) ? 3'h0 : 3'h1 << sp, !wr, wr, wr,
			(slow && w != 3'h0) ? 8'hFF : 8'(1 + w)});
		// Callers drop req in the step done rises; the back-to-back loop keeps it high, so the next access starts
		@(posedge done);
	endtask : access

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	always @(posedge core_clk iff rst_n) begin
		logic [23:0] e;
		logic [7:0]  c;
		cmp("data drive", {15'h0, write_strobe_n}, {15'h0, data_bus_oe_n});
		if (done === 1'h1) begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hFFFFFF;
			c = (e[7:0] == 8'hFF && ocnt > e[23:16] && ocnt < e[23:16] + 8'h14) ? 8'hFF : ocnt;
			cmp("access", e[15:0], {2'h0, osp, ord, owr, odl, c});
			{ocnt, osp, ord, owr, odl} = 0;
		end
		if (ext_access_strobe_n === 1'h0) begin
			ocnt++;
			osp |= ~{io_space_select_n, data_space_strobe_n, prog_space_strobe_n};
			ord |= !read_strobe_n;
			owr |= !write_strobe_n;
			odl |= !rd_wr_dir;
			cmp("qualifier", {15'h0, !rd_wr_dir}, {15'h0, port_c_bit0_gpio_o});
		end else begin
			cmp("idle strobes", 16'h3F, {10'h0, read_strobe_n, write_strobe_n, prog_space_strobe_n,
				data_space_strobe_n, io_space_select_n, rd_wr_dir});
		end
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		repeat (4) @(posedge core_clk);
		cmp("gpio reset", 16'h1, {15'h0, port_c_bit0_gpio_oe_n});
		rng = xs(rng);
		port_c_bit0_gpio_dir_out <= 1'h1;
		port_c_bit0_gpio_out <= rng[0];
		port_c_bit0_gpio_i <= rng[1];
		repeat (5) @(posedge core_clk);
		cmp("gpio", {14'h0, rng[0], rng[1]}, {13'h0, port_c_bit0_gpio_oe_n, port_c_bit0_gpio_o,
			port_c_bit0_gpio_val});
		port_c_bit0_sel_qual <= 1'h1;
		repeat (4) @(posedge core_clk);
		// Every direction and space code, back to back
		for (int i = 0; i < 8; i++) begin
			access(i[2], i[1:0], 3'h0);
		end
		req <= 1'h0;
		for (int i = 0; i < 16; i++) begin
			rng = xs(rng);
			slow <= rng[4] & (rng[6:5] != 2'h0);
			repeat (4) @(posedge core_clk);
			access(rng[0], rng[2:1], {1'h0, rng[6:5]});
			req <= 1'h0;
		end
		slow <= 1'h1;
		repeat (4) @(posedge core_clk);
		access(1'h0, 2'h1, 3'h0);
		req <= 1'h0;
		slow <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			{debug_pin_one_float_n, test_reset, debug_pin_zero} <= i[2:0];
			repeat (5) @(posedge core_clk);
			cmp("float", {15'h0, i[2:0] == 3'h1}, {15'h0, strobe_oe_n});
		end
		repeat (4) @(posedge core_clk);
		test_done();
	end
endmodule : tb_ext_bus_strobe_control

// File: logic/ebs_pkg.sv
// Purpose: shared constants and types of the external bus strobe control
// Assumes: one core clock at 10 MHz
// Notes:   bus strobes are active low at the pins
package ebs_pkg;

	// ---------------------------------------------------------------
	// Access kinds and address spaces
	// ---------------------------------------------------------------
	localparam logic [1:0] EBS_SPACE_PROG = 2'h0;
	localparam logic [1:0] EBS_SPACE_DATA = 2'h1;
	localparam logic [1:0] EBS_SPACE_IO   = 2'h2;

	// ---------------------------------------------------------------
	// Wait-state configuration
	// ---------------------------------------------------------------
	localparam int         EBS_WS_W       = 3;
	localparam logic [2:0] EBS_WS_ZERO    = 3'h0;
	localparam logic [2:0] EBS_WS_ONE     = 3'h1;

	// ---------------------------------------------------------------
	// Pin idle levels
	// ---------------------------------------------------------------
	localparam logic       EBS_EXT_ACCESS_STROBE_IDLE  = 1'h1;
	localparam logic       EBS_DIR_READ   = 1'h1;
	localparam logic       EBS_OE_ON      = 1'h0;
	localparam logic       EBS_OE_OFF     = 1'h1;

	typedef enum logic [1:0] {
		EBS_IDLE,
		EBS_ACCESS,
		EBS_WAIT
	} ebs_state_t;

endpackage : ebs_pkg

// File: logic/ebs_strobe_ctrl.sv
// Purpose: control strobes of the external memory interface
// Assumes: core issues one access request at a time, held until done
// Notes:   strobes active low; float only under the debug pin condition
module ebs_strobe_ctrl
(
	// Clock and reset
	input  wire logic                    core_clk,
	input  wire logic                    rst_n,
	// Core request side
	input  wire logic                    req,
	input  wire logic                    req_write,
	input  wire logic [1:0]              req_space,
	input  wire logic [ebs_pkg::EBS_WS_W-1:0] wait_state_config,
	input  wire logic                    port_c_bit0_sel_qual,
	input  wire logic                    port_c_bit0_gpio_dir_out,
	input  wire logic                    port_c_bit0_gpio_out,
	output logic                         done,
	// Pins from outside
	input  wire logic                    ready,
	input  wire logic                    debug_pin_one_float_n,
	input  wire logic                    test_reset,
	input  wire logic                    debug_pin_zero,
	input  wire logic                    port_c_bit0_gpio_i,
	output logic                         port_c_bit0_gpio_val,
	// Strobes, value and output enable (enable low drives)
	output logic                         ext_access_strobe_n,
	output logic                         read_strobe_n,
	output logic                         write_strobe_n,
	output logic                         rd_wr_dir,
	output logic                         prog_space_strobe_n,
	output logic                         data_space_strobe_n,
	output logic                         io_space_select_n,
	output logic                         strobe_oe_n,
	output logic                         port_c_bit0_gpio_o,
	output logic                         port_c_bit0_gpio_oe_n,
	output logic                         data_bus_oe_n
);

	import ebs_pkg::*;

	// ---------------------------------------------------------------
	// Reset release and pin synchronisers
	// ---------------------------------------------------------------
	logic       rst_meta_q;
	logic       rst_sync_n;
	logic [4:0] pins_sync;
	wire        ready_s;
	wire        float_s_n;
	wire        trst_s;
	wire        debug_pin_zero_s;
	wire        gpio_s;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'h0;
			rst_sync_n <= 1'h0;
		end else begin
			rst_meta_q <= 1'h1;
			rst_sync_n <= rst_meta_q;
		end
	end

	// Pin stages clear with the internal reset, so no stale READY survives it
	ebs_sync #(.W(5)) u_sync (
		.core_clk (core_clk),
		.rst_n    (rst_sync_n),
		.async_in ({ready, debug_pin_one_float_n, test_reset, debug_pin_zero, port_c_bit0_gpio_i}),
		.sync_out (pins_sync)
	);

	// Pins are unrelated, so per-bit synchronising is enough
	assign ready_s   = pins_sync[4];
	assign float_s_n = pins_sync[3];
	assign trst_s    = pins_sync[2];
	assign debug_pin_zero_s    = pins_sync[1];
	assign gpio_s    = pins_sync[0];

	// ---------------------------------------------------------------
	// Access sequencer
	// ---------------------------------------------------------------
	ebs_state_t          state_q;
	ebs_state_t          state_d;
	logic [EBS_WS_W-1:0] ws_cnt_q;
	logic [EBS_WS_W-1:0] ws_cnt_d;
	logic                wr_q;
	logic [1:0]          space_q;
	wire                 ws_left;
	wire                 ready_watch;
	wire                 finish;
	wire                 active_d;

	assign ws_left     = (ws_cnt_q != EBS_WS_ZERO);
	// Zero wait states never look at READY
	assign ready_watch = (wait_state_config >= EBS_WS_ONE);
	// Low READY stretches by one cycle, then looks again
	assign finish      = !ws_left && (!ready_watch || ready_s);

	always_comb begin
		state_d  = state_q;
		ws_cnt_d = ws_cnt_q;
		unique case (state_q)
			EBS_IDLE: begin
				if (req) begin
					state_d  = EBS_ACCESS;
					ws_cnt_d = wait_state_config;
				end
			end
			EBS_ACCESS, EBS_WAIT: begin
				if (ws_left) begin
					ws_cnt_d = ws_cnt_q - EBS_WS_ONE;
					state_d  = EBS_WAIT;
				end else if (finish) begin
					state_d = EBS_IDLE;
				end else begin
					state_d = EBS_WAIT;
				end
			end
		endcase
	end

	assign active_d = (state_d != EBS_IDLE);

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_q  <= EBS_IDLE;
			ws_cnt_q <= EBS_WS_ZERO;
			wr_q     <= 1'h0;
			space_q  <= EBS_SPACE_PROG;
		end else begin
			state_q  <= state_d;
			ws_cnt_q <= ws_cnt_d;
			if (state_q == EBS_IDLE && req) begin
				wr_q    <= req_write;
				space_q <= req_space;
			end
		end
	end

	// ---------------------------------------------------------------
	// Strobe next values
	// ---------------------------------------------------------------
	wire wr_d;
	wire sp_d;
	wire [1:0] space_d;

	// In the start cycle the strobes follow the live request
	assign wr_d    = (state_q == EBS_IDLE) ? req_write : wr_q;
	assign space_d = (state_q == EBS_IDLE) ? req_space : space_q;
	assign sp_d    = active_d;

	wire ext_access_strobe_d  = sp_d ? 1'h0 : EBS_EXT_ACCESS_STROBE_IDLE;
	wire rd_d    = !(sp_d && !wr_d);
	// Write strobe and data drive share one edge
	wire we_d    = !(sp_d && wr_d);
	wire dir_d   = (sp_d && wr_d) ? !EBS_DIR_READ : EBS_DIR_READ;
	wire ps_d    = !(sp_d && space_d == EBS_SPACE_PROG);
	wire ds_d    = !(sp_d && space_d == EBS_SPACE_DATA);
	wire is_d    = !(sp_d && space_d == EBS_SPACE_IO);
	// Float needs all three debug conditions together
	wire float_d = !float_s_n && !trst_s && debug_pin_zero_s;
	// Done leaves with the strobes' return; a held request restarts next edge
	wire done_d  = (state_q != EBS_IDLE) && finish;
	// Qualifier is the plain inverse of direction
	wire qual_d  = !dir_d;
	wire gp_out  = port_c_bit0_sel_qual ? qual_d : port_c_bit0_gpio_out;
	wire gp_oe   = (port_c_bit0_sel_qual || port_c_bit0_gpio_dir_out) ? EBS_OE_ON : EBS_OE_OFF;

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ext_access_strobe_n   <= EBS_EXT_ACCESS_STROBE_IDLE;
			read_strobe_n         <= EBS_EXT_ACCESS_STROBE_IDLE;
			write_strobe_n        <= EBS_EXT_ACCESS_STROBE_IDLE;
			rd_wr_dir             <= EBS_DIR_READ;
			prog_space_strobe_n   <= EBS_EXT_ACCESS_STROBE_IDLE;
			data_space_strobe_n   <= EBS_EXT_ACCESS_STROBE_IDLE;
			io_space_select_n     <= EBS_EXT_ACCESS_STROBE_IDLE;
			strobe_oe_n           <= EBS_OE_ON;
			port_c_bit0_gpio_o    <= 1'h0;
			port_c_bit0_gpio_oe_n <= EBS_OE_OFF;
			port_c_bit0_gpio_val  <= 1'h0;
			data_bus_oe_n         <= EBS_OE_OFF;
			done                  <= 1'h0;
		end else begin
			ext_access_strobe_n   <= ext_access_strobe_d;
			read_strobe_n         <= rd_d;
			write_strobe_n        <= we_d;
			rd_wr_dir             <= dir_d;
			prog_space_strobe_n   <= ps_d;
			data_space_strobe_n   <= ds_d;
			io_space_select_n     <= is_d;
			strobe_oe_n           <= float_d ? EBS_OE_OFF : EBS_OE_ON;
			port_c_bit0_gpio_o    <= gp_out;
			port_c_bit0_gpio_oe_n <= gp_oe;
			port_c_bit0_gpio_val  <= gpio_s;
			data_bus_oe_n         <= we_d ? EBS_OE_OFF : EBS_OE_ON;
			done                  <= done_d;
		end
	end

	// ---------------------------------------------------------------
	// Access length tracking for the checks
	// ---------------------------------------------------------------
	// Saturates, so a device that holds READY low for long cannot wrap it
	logic [EBS_WS_W:0] len_q;
	wire  [EBS_WS_W:0] len_d;
	wire               len_full;

	assign len_full = &len_q;
	assign len_d    = (state_q == EBS_IDLE) ? '0 : len_q + {{EBS_WS_W{1'h0}}, !len_full};

	always_ff @(posedge core_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			len_q <= '0;
		end else begin
			len_q <= len_d;
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_sync_n);

	// Qualifier pin is registered, so its checks lag the selection by one edge
	qual_inverse_a: assert property ($past(port_c_bit0_sel_qual) |-> !port_c_bit0_gpio_oe_n
		&& port_c_bit0_gpio_o == !rd_wr_dir) else $error("qualifier not inverse of direction");
	qual_write_only_a: assert property ($past(port_c_bit0_sel_qual) && port_c_bit0_gpio_o
		|-> !write_strobe_n) else $error("qualifier high outside write");

	// Strobes and bus cycle
	read_strobe_a: assert property (!read_strobe_n |-> !ext_access_strobe_n && rd_wr_dir)
		else $error("read strobe outside read cycle");
	rw_excl_a: assert property (read_strobe_n || write_strobe_n)
		else $error("read and write strobes low together");
	we_data_a: assert property (write_strobe_n == data_bus_oe_n)
		else $error("write strobe and data drive apart");
	write_strobe_a: assert property ($past(state_q) == EBS_IDLE && state_q != EBS_IDLE && wr_q
		|-> !write_strobe_n) else $error("write without write strobe");
	write_dir_a: assert property (!write_strobe_n |-> !rd_wr_dir && !ext_access_strobe_n)
		else $error("write strobe outside write cycle");
	ext_access_strobe_cycle_a: assert property (state_q == EBS_IDLE |-> ext_access_strobe_n)
		else $error("access strobe low while idle");
	strobe_pair_a: assert property (ext_access_strobe_n |-> read_strobe_n && write_strobe_n && rd_wr_dir
		&& prog_space_strobe_n && data_space_strobe_n && io_space_select_n) else $error("strobe low outside cycle");
	done_strobe_a: assert property (done |-> ext_access_strobe_n)
		else $error("done before access strobe returned");
	ext_access_strobe_every_a: assert property (!read_strobe_n || !write_strobe_n |-> !ext_access_strobe_n)
		else $error("off-chip access without access strobe");
	req_start_a: assert property (state_q == EBS_IDLE && req |=> !ext_access_strobe_n)
		else $error("request did not open a bus cycle");

	// Wait states and READY
	ready_wait_a: assert property (state_q != EBS_IDLE && !ws_left && ready_watch && !ready_s
		|=> state_q == EBS_WAIT) else $error("low READY did not stretch");
	ready_done_a: assert property (state_q != EBS_IDLE && !ws_left && ready_watch && ready_s
		|=> state_q == EBS_IDLE && done) else $error("high READY did not end the access");
	ready_ignore_a: assert property (state_q != EBS_IDLE && wait_state_config == EBS_WS_ZERO && !ws_left
		|=> state_q == EBS_IDLE) else $error("READY watched with no wait states");
	ws_hold_a: assert property (state_q != EBS_IDLE && ws_left |=> !ext_access_strobe_n)
		else $error("access ended inside its wait states");
	// A cycle never ends before its programmed wait states have run
	len_check_a: assert property (done |-> len_q > {1'h0, wait_state_config})
		else $error("access shorter than its wait states");

	// Pin state and floating
	float_cond_a: assert property (strobe_oe_n |-> $past(!float_s_n && !trst_s && debug_pin_zero_s))
		else $error("strobes floated without debug condition");
	float_on_a: assert property ($past(!float_s_n && !trst_s && debug_pin_zero_s) |-> strobe_oe_n)
		else $error("debug condition did not float strobes");
	gpio_input_a: assert property ($past(!port_c_bit0_sel_qual && !port_c_bit0_gpio_dir_out)
		|-> port_c_bit0_gpio_oe_n) else $error("unselected pin not an input");
	space_one_a: assert property ($countones({prog_space_strobe_n, data_space_strobe_n,
		io_space_select_n}) >= 2) else $error("two space selects low");
	space_in_cycle_a: assert property (!(prog_space_strobe_n && data_space_strobe_n && io_space_select_n)
		|-> !ext_access_strobe_n) else $error("space select low outside bus cycle");
	space_kept_a: assert property (!ext_access_strobe_n && $past(!ext_access_strobe_n)
		|-> $stable({prog_space_strobe_n, data_space_strobe_n, io_space_select_n})) else $error("space changed mid cycle");
	dir_write_a: assert property (!rd_wr_dir |-> !write_strobe_n)
		else $error("direction low without write");

	read_cov_c:  cover property (!read_strobe_n ##1 read_strobe_n);
	write_cov_c: cover property (!write_strobe_n ##1 write_strobe_n);
	wait_cov_c:  cover property (state_q == EBS_WAIT && ready_watch && !ready_s ##1 state_q == EBS_WAIT);
	float_cov_c: cover property (strobe_oe_n);
	io_cov_c:    cover property (!io_space_select_n && !write_strobe_n);

endmodule : ebs_strobe_ctrl

// File: logic/ebs_sync.sv
// Purpose: two flip-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes:   first stage read only by the second stage
module ebs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : ebs_sync
